// *** hw/adcc_dev.sv ***
// Function
// R1: Bit five of config_reg_a picks clock source
// R2: Source changes at write strobe rising edge
// R3: Zero selects oscillator, one selects external clock
// R4: Oscillator starts within half period of trigger
// R5: config_reg_b bit selects oscillator speed
// R6: Host supplies external clock, 1 to 20 MHz
// R7: Ten-bit data bus, done flag, strobes
// R8: Single-ended codes run zero to 1023
// R9: config_reg_b bit selects binary or twos complement
// R10: Host lowers select before any cycle
// R11: Done output high right after power-up
// R12: Host writes both configuration registers first
// R13: Host discards first result after power-down (host marks only the first result after reset invalid)
// R14: Full throughput needs 20 MHz conversion clock
// R15: Low supply throughput needs 10 MHz clock
// R16: Software sampling lasts six conversion clocks
// R17: Conversion follows at once, ten clocks
// R18: Hardware start samples low, converts on rise
// R19: Software start samples from write rising edge
// R20: No read next clock: enter power-down (only after a software start; a hardware-start result never powers down)
// R21: Source switching never glitches conversion clock
`timescale 1ns/1ps
module adcc_dev
  import adcc_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Link to host
  adcc_link_if.dev        link,
  // Converter core
  input  wire logic [9:0] i_sample_code,
  // Status
  output logic [9:0]      o_result,
  output logic            o_clk_src,
  output logic            o_busy,
  output logic            o_powered_down
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] p1;
    logic [4:0] p2;
    logic [4:0] p3;
    logic [9:0] d1;
    logic [9:0] d2;
    adcc_dev_e  st;
    logic [3:0] cnt;
    logic [3:0] osc_cnt;
    logic [9:0] cfg_a;
    logic [9:0] cfg_b;
    logic       clk_src;
    logic       sw_run;
    logic [9:0] sample;
    logic [9:0] result;
    logic       d_oe;
    logic       eoc;
    logic       busy;
    logic       pdown;
  } adcc_dev_s;

  localparam int P_CS  = 4;
  localparam int P_RD  = 3;
  localparam int P_WR  = 2;
  localparam int P_CST = 1;
  localparam int P_EXT = 0;

  adcc_dev_s r_r;
  adcc_dev_s r_nxt;

  logic [4:0] pins;
  logic       cs_lo;
  logic       wr_rise;
  logic       wr_fall;
  logic       rd_fall;
  logic       cst_rise;
  logic       cst_fall;
  logic       ext_rise;
  logic       osc_run;
  logic       osc_tick;
  logic       tick;
  logic       trig_fall;
  logic       busy;
  logic [3:0] osc_div;

  assign pins = {link.cs_n, link.rd_n, link.wr_n, link.hardware_convert_start_n, link.ext_clk};

  // ----------------------------------------------------------------
  // Edge detection on synchronised pins
  // ----------------------------------------------------------------
  always_comb begin
    cs_lo     = ~r_r.p2[P_CS];
    wr_rise   = r_r.p2[P_WR] & ~r_r.p3[P_WR];
    wr_fall   = ~r_r.p2[P_WR] & r_r.p3[P_WR];
    rd_fall   = ~r_r.p2[P_RD] & r_r.p3[P_RD];
    cst_rise  = r_r.p2[P_CST] & ~r_r.p3[P_CST];
    cst_fall  = ~r_r.p2[P_CST] & r_r.p3[P_CST];
    ext_rise  = r_r.p2[P_EXT] & ~r_r.p3[P_EXT];
    trig_fall = (cs_lo & (wr_fall | rd_fall)) | cst_fall;
    busy      = (r_r.st == DS_SAMPLE) | (r_r.st == DS_HWSAMP) | (r_r.st == DS_CONV);
  end

  // ----------------------------------------------------------------
  // Conversion clock generation
  // ----------------------------------------------------------------
  always_comb begin
    // R5: oscillator speed
    osc_div  = r_r.cfg_b[OSC_SPEED_BIT] ? OSC_DIV_FAST : OSC_DIV_SLOW;
    osc_run  = busy | (r_r.st == DS_DONE);
    osc_tick = osc_run & (r_r.osc_cnt == osc_div - 4'h1);
    // R3: source select; R21: whole-tick mux, no partial pulse
    tick     = (r_r.clk_src == SRC_EXT) ? ext_rise : osc_tick;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_nxt    = r_r;
    r_nxt.p1 = pins;
    r_nxt.p2 = r_r.p1;
    r_nxt.p3 = r_r.p2;
    r_nxt.d1 = link.d;
    r_nxt.d2 = r_r.d1;

    // R4: gated oscillator restarts at each trigger fall
    if (!osc_run || trig_fall || osc_tick) begin
      r_nxt.osc_cnt = 4'h0;
    end else begin
      r_nxt.osc_cnt = r_r.osc_cnt + 4'h1;
    end

    // R7: drive data while selected and read low
    r_nxt.d_oe = cs_lo & ~r_r.p2[P_RD];

    unique case (r_r.st)
      DS_IDLE: begin
      end
      DS_SAMPLE: begin
        if (tick) begin
          r_nxt.cnt = r_r.cnt + 4'h1;
          // R16: six-tick sampling window
          if (r_r.cnt == SAMPLE_TICKS - 4'h1) begin
            r_nxt.sample = i_sample_code;
            r_nxt.cnt    = 4'h0;
            // R17: conversion follows immediately
            r_nxt.st     = DS_CONV;
          end
        end
      end
      DS_HWSAMP: begin
        // R18: conversion begins on start rising edge
        if (cst_rise) begin
          r_nxt.sample = i_sample_code;
          r_nxt.cnt    = 4'h0;
          r_nxt.st     = DS_CONV;
        end
      end
      DS_CONV: begin
        if (tick) begin
          r_nxt.cnt = r_r.cnt + 4'h1;
          // R17: ten-tick conversion
          if (r_r.cnt == CONV_TICKS - 4'h1) begin
            r_nxt.cnt    = 4'h0;
            // R8, R9: unipolar code, optional twos complement
            r_nxt.result = adcc_format(r_r.sample, r_r.cfg_b[FORMAT_BIT]);
            r_nxt.eoc    = 1'b1;
            r_nxt.st     = DS_DONE;
          end
        end
      end
      DS_DONE: begin
        if (cs_lo && rd_fall) begin
          r_nxt.st = DS_IDLE;
        // R20: after a software start, no read within next tick powers down
        end else if (tick && r_r.sw_run) begin
          r_nxt.st    = DS_PDOWN;
          r_nxt.pdown = 1'b1;
        end
      end
      DS_PDOWN: begin
      end
      default: begin
        r_nxt.st = DS_IDLE;
      end
    endcase

    // Register writes on write strobe rising edge
    if (cs_lo && wr_rise) begin
      if (r_r.d2[REG_SEL_BIT]) begin
        r_nxt.cfg_b = r_r.d2;
      end else begin
        r_nxt.cfg_a   = r_r.d2;
        // R1, R2: source taken from the write that programs it
        r_nxt.clk_src = r_r.d2[CLK_SRC_BIT];
        // R19: software start samples from write rise
        if (!r_r.d2[HW_MODE_BIT] && !busy) begin
          r_nxt.st     = DS_SAMPLE;
          r_nxt.cnt    = 4'h0;
          r_nxt.sw_run = 1'b1;
          r_nxt.eoc    = 1'b0;
          r_nxt.pdown  = 1'b0;
        end
      end
    end

    // R18: hardware start samples while input low
    if (cst_fall && r_r.cfg_a[HW_MODE_BIT] && !busy) begin
      r_nxt.st     = DS_HWSAMP;
      r_nxt.cnt    = 4'h0;
      r_nxt.sw_run = 1'b0;
      r_nxt.eoc    = 1'b0;
      r_nxt.pdown  = 1'b0;
    end

    r_nxt.busy = (r_nxt.st == DS_SAMPLE) | (r_nxt.st == DS_HWSAMP) | (r_nxt.st == DS_CONV);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r_r         <= '0;
      r_r.p1      <= 5'h1F;
      r_r.p2      <= 5'h1F;
      r_r.p3      <= 5'h1F;
      r_r.st      <= DS_IDLE;
      r_r.cfg_a   <= CFG_RESET;
      r_r.cfg_b   <= CFG_RESET;
      r_r.clk_src <= SRC_OSC;
      // R11: done output high from power-up
      r_r.eoc     <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.d_dev_out = r_r.result;
  assign link.d_dev_oe  = r_r.d_oe;
  assign link.int_eoc   = r_r.eoc;
  assign o_result       = r_r.result;
  assign o_clk_src      = r_r.clk_src;
  assign o_busy         = r_r.busy;
  assign o_powered_down = r_r.pdown;

endmodule : adcc_dev

// *** hw/adcc_pkg.sv ***
package adcc_pkg;

  // ----------------------------------------------------------------
  // Clock and link widths
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int DW          = 10;

  // ----------------------------------------------------------------
  // Configuration field positions
  // ----------------------------------------------------------------
  localparam int REG_SEL_BIT   = 9;  // 0: config_reg_a, 1: config_reg_b
  localparam int CLK_SRC_BIT   = 5;  // clock_source_select in config_reg_a
  localparam int HW_MODE_BIT   = 7;  // Hardware start mode in config_reg_a
  localparam int OSC_SPEED_BIT = 6;  // osc_speed_select in config_reg_b
  localparam int FORMAT_BIT    = 3;  // output_code_format_select in config_reg_b

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [9:0] CFG_RESET = 10'h000;
  localparam logic [9:0] CODE_MAX  = 10'h3FF;  // Unipolar full scale
  localparam logic [9:0] SIGN_FLIP = 10'h200;  // Offset binary to twos complement
  localparam logic       SRC_OSC   = 1'h0;
  localparam logic       SRC_EXT   = 1'h1;

  // ----------------------------------------------------------------
  // Conversion timing in conversion clock ticks
  // ----------------------------------------------------------------
  localparam logic [3:0] SAMPLE_TICKS = 4'h6;
  localparam logic [3:0] CONV_TICKS   = 4'hA;
  // Scaled oscillator model: system clocks per oscillator tick
  localparam logic [3:0] OSC_DIV_SLOW = 4'h4;  // Nominal 10 MHz setting
  localparam logic [3:0] OSC_DIV_FAST = 4'h2;  // Nominal 20 MHz setting

  // ----------------------------------------------------------------
  // Host side timing
  // ----------------------------------------------------------------
  localparam int         EXT_CLK_HZ   = 2_500_000;
  localparam int         EXT_HALF_INT = CLK_FREQ_HZ / (2 * EXT_CLK_HZ);
  localparam logic [3:0] EXT_HALF_CYC = 4'(EXT_HALF_INT);
  localparam logic [3:0] STROBE_CYC   = 4'h8;
  localparam logic [3:0] HOLD_CYC     = 4'h3;

  // ----------------------------------------------------------------
  // Host command port map
  // ----------------------------------------------------------------
  localparam logic [1:0] A_DEV_WRITE = 2'h0;  // Write: bus write / Read: status
  localparam logic [1:0] A_DEV_READ  = 2'h1;  // Write: bus read / Read: data
  localparam logic [1:0] A_HW_START  = 2'h2;  // Bit 0 holds start pin asserted
  localparam int ST_BUSY  = 0;
  localparam int ST_EOC   = 1;
  localparam int ST_VALID = 2;
  localparam int ST_CFG_A = 3;
  localparam int ST_CFG_B = 4;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DS_IDLE   = 3'h0,
    DS_SAMPLE = 3'h1,
    DS_HWSAMP = 3'h2,
    DS_CONV   = 3'h3,
    DS_DONE   = 3'h4,
    DS_PDOWN  = 3'h5
  } adcc_dev_e;

  typedef enum logic [1:0] {
    HS_IDLE   = 2'h0,
    HS_SETUP  = 2'h1,
    HS_STROBE = 2'h2,
    HS_HOLD   = 2'h3
  } adcc_host_e;

  // Output code formatting
  function automatic logic [9:0] adcc_format(input logic [9:0] code, input logic twos);
    adcc_format = twos ? (code ^ SIGN_FLIP) : code;
  endfunction : adcc_format

endpackage : adcc_pkg

// *** hw/adcc_link_if.sv ***
`timescale 1ns/1ps
interface adcc_link_if;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic       hardware_convert_start_n;
  logic       ext_clk;
  logic [9:0] d_host_out;
  logic       d_host_oe;
  logic [9:0] d_dev_out;
  logic       d_dev_oe;
  logic       int_eoc;
  logic [9:0] d;

  // Resolved data bus, pulled high when nobody drives
  assign d = d_dev_oe ? d_dev_out : (d_host_oe ? d_host_out : 10'h3FF);

  modport dev (
    input  cs_n, rd_n, wr_n, hardware_convert_start_n, ext_clk, d,
    output d_dev_out, d_dev_oe, int_eoc
  );
  modport host (
    input  d, int_eoc,
    output cs_n, rd_n, wr_n, hardware_convert_start_n, ext_clk, d_host_out, d_host_oe
  );
endinterface : adcc_link_if

// *** hw/adcc_host.sv ***
`timescale 1ns/1ps
module adcc_host
  import adcc_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Command port
  input  wire logic [1:0] i_addr,
  input  wire logic [9:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic [9:0]      o_rdata,
  // Link to device
  adcc_link_if.host       link
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    adcc_host_e st;
    logic [3:0] cnt;
    logic       is_wr;
    logic [9:0] wdata;
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       d_oe;
    logic       cst_n;
    logic       ext_clk;
    logic [3:0] ext_cnt;
    logic       e1;
    logic       e2;
    logic [9:0] q1;
    logic [9:0] q2;
    logic [9:0] data;
    logic       valid;
    logic       discard;
    logic       cfg_a;
    logic       cfg_b;
    logic [9:0] rdata;
  } adcc_host_s;

  adcc_host_s r_r;
  adcc_host_s r_nxt;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_nxt       = r_r;
    r_nxt.e1    = link.int_eoc;
    r_nxt.e2    = r_r.e1;
    r_nxt.q1    = link.d;
    r_nxt.q2    = r_r.q1;
    r_nxt.rdata = 10'h000;

    // R6, R14, R15: free-running external clock from divider
    if (r_r.ext_cnt == EXT_HALF_CYC - 4'h1) begin
      r_nxt.ext_cnt = 4'h0;
      r_nxt.ext_clk = ~r_r.ext_clk;
    end else begin
      r_nxt.ext_cnt = r_r.ext_cnt + 4'h1;
    end

    // Command port reads
    if (i_rd) begin
      if (i_addr == A_DEV_WRITE) begin
        r_nxt.rdata[ST_BUSY]  = (r_r.st != HS_IDLE);
        r_nxt.rdata[ST_EOC]   = r_r.e2;
        r_nxt.rdata[ST_VALID] = r_r.valid;
        r_nxt.rdata[ST_CFG_A] = r_r.cfg_a;
        r_nxt.rdata[ST_CFG_B] = r_r.cfg_b;
      end else if (i_addr == A_DEV_READ) begin
        r_nxt.rdata = r_r.data;
      end
    end

    if (i_wr && i_addr == A_HW_START) begin
      r_nxt.cst_n = ~i_wdata[0];
    end

    unique case (r_r.st)
      HS_IDLE: begin
        if (i_wr && (i_addr == A_DEV_WRITE || i_addr == A_DEV_READ)) begin
          // R10: select goes low one cycle ahead of strobe
          r_nxt.cs_n  = 1'b0;
          r_nxt.is_wr = (i_addr == A_DEV_WRITE);
          r_nxt.d_oe  = (i_addr == A_DEV_WRITE);
          r_nxt.wdata = i_wdata;
          r_nxt.st    = HS_SETUP;
        end
      end
      HS_SETUP: begin
        r_nxt.wr_n = ~r_r.is_wr;
        r_nxt.rd_n = r_r.is_wr;
        r_nxt.cnt  = 4'h0;
        r_nxt.st   = HS_STROBE;
      end
      HS_STROBE: begin
        r_nxt.cnt = r_r.cnt + 4'h1;
        if (r_r.cnt == STROBE_CYC - 4'h1) begin
          r_nxt.wr_n = 1'b1;
          r_nxt.rd_n = 1'b1;
          r_nxt.cnt  = 4'h0;
          r_nxt.st   = HS_HOLD;
          if (r_r.is_wr) begin
            // R12: track that both registers were loaded
            r_nxt.cfg_a = r_r.cfg_a | ~r_r.wdata[REG_SEL_BIT];
            r_nxt.cfg_b = r_r.cfg_b | r_r.wdata[REG_SEL_BIT];
          end else begin
            r_nxt.data    = r_r.q2;
            // R13: first result after power-up is marked invalid
            r_nxt.valid   = ~r_r.discard;
            r_nxt.discard = 1'b0;
          end
        end
      end
      HS_HOLD: begin
        r_nxt.cnt = r_r.cnt + 4'h1;
        if (r_r.cnt == HOLD_CYC - 4'h1) begin
          r_nxt.cs_n = 1'b1;
          r_nxt.d_oe = 1'b0;
          r_nxt.st   = HS_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r_r         <= '0;
      r_r.st      <= HS_IDLE;
      r_r.cs_n    <= 1'b1;
      r_r.rd_n    <= 1'b1;
      r_r.wr_n    <= 1'b1;
      r_r.cst_n   <= 1'b1;
      r_r.e1      <= 1'b1;
      r_r.e2      <= 1'b1;
      r_r.discard <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rdata                       = r_r.rdata;
  assign link.cs_n                     = r_r.cs_n;
  assign link.rd_n                     = r_r.rd_n;
  assign link.wr_n                     = r_r.wr_n;
  assign link.hardware_convert_start_n = r_r.cst_n;
  assign link.ext_clk                  = r_r.ext_clk;
  assign link.d_host_out               = r_r.wdata;
  assign link.d_host_oe                = r_r.d_oe;

endmodule : adcc_host

// *** bench/adcc_link_assertions.sv ***
`timescale 1ns/1ps
module adcc_link_assertions (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Link signals
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       ext_clk,
  input  wire logic [9:0] d_host_out,
  input  wire logic       d_host_oe,
  input  wire logic       d_dev_oe,
  input  wire logic       int_eoc
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // ----------------------------------------------------------------
  // Strobe shapes
  // ----------------------------------------------------------------
  sequence s_low8(s);
    (!s)[*8] ##1 s;
  endsequence
  sequence s_cs_hold;
    (!cs_n)[*3] ##1 cs_n;
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_eoc_reset;
    $rose(i_resetn) |-> int_eoc;
  endproperty
  property p_wr_len;
    $fell(wr_n) |-> s_low8(wr_n);
  endproperty
  property p_rd_len;
    $fell(rd_n) |-> s_low8(rd_n);
  endproperty
  property p_cs_first;
    $fell(wr_n) || $fell(rd_n) |-> !$past(cs_n);
  endproperty
  property p_cs_hold;
    $rose(wr_n) || $rose(rd_n) |-> s_cs_hold;
  endproperty
  property p_no_fight;
    !(d_dev_oe && d_host_oe);
  endproperty
  property p_dev_oe_src;
    $rose(d_dev_oe) |-> !cs_n && !rd_n;
  endproperty
  property p_dev_oe_drop;
    $rose(rd_n) |-> ##[1:5] !d_dev_oe;
  endproperty
  property p_wr_data;
    !wr_n |-> $stable(d_host_out) && d_host_oe;
  endproperty
  property p_ext_half;
    $changed(ext_clk) |=> $stable(ext_clk);
  endproperty
  property p_eoc_bound;
    $fell(int_eoc) |-> ##[1:600] int_eoc;
  endproperty

  a_eoc_reset: assert property (p_eoc_reset)
    else $error("done flag low after reset");
  a_wr_len: assert property (p_wr_len)
    else $error("write strobe length wrong");
  a_rd_len: assert property (p_rd_len)
    else $error("read strobe length wrong");
  a_cs_first: assert property (p_cs_first)
    else $error("strobe without prior select");
  a_cs_hold: assert property (p_cs_hold)
    else $error("select hold wrong");
  a_no_fight: assert property (p_no_fight)
    else $error("both ends drive data bus");
  a_dev_oe_src: assert property (p_dev_oe_src)
    else $error("device drives bus unselected");
  a_dev_oe_drop: assert property (p_dev_oe_drop)
    else $error("device keeps driving bus");
  a_wr_data: assert property (p_wr_data)
    else $error("write data moves under strobe");
  a_ext_half: assert property (p_ext_half)
    else $error("external clock half period short");
  a_eoc_bound: assert property (p_eoc_bound)
    else $error("conversion never ends");
endmodule : adcc_link_assertions

// *** bench/adc_clock_and_host_config_bench.sv ***
`timescale 1ns/1ps
module adc_clock_and_host_config_bench;
  import adcc_pkg::*;
  logic       i_clk, i_resetn, i_wr, i_rd;
  logic [1:0] i_addr;
  logic [9:0] i_wdata, o_rdata, i_sample_code, o_result;
  logic       o_clk_src, o_busy, o_powered_down;
  logic       bsy_q = 1'b0;
  int         error_cnt, tests_run;
  int         bsy_len = 0;

  adcc_link_if link_if ();
  adcc_dev adcc_dev_inst (.i_clk(i_clk), .i_resetn(i_resetn), .link(link_if),
    .i_sample_code(i_sample_code), .o_result(o_result), .o_clk_src(o_clk_src),
    .o_busy(o_busy), .o_powered_down(o_powered_down));
  adcc_host adcc_host_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .link(link_if));
  adcc_link_assertions adcc_link_assertions_inst (.i_clk(i_clk), .i_resetn(i_resetn),
    .cs_n(link_if.cs_n), .rd_n(link_if.rd_n), .wr_n(link_if.wr_n),
    .ext_clk(link_if.ext_clk), .d_host_out(link_if.d_host_out),
    .d_host_oe(link_if.d_host_oe), .d_dev_oe(link_if.d_dev_oe),
    .int_eoc(link_if.int_eoc));

  // Clock generator
  always #50 i_clk = ~i_clk;

  // Busy length meter
  always @(posedge i_clk) begin
    bsy_q <= o_busy;
    if (o_busy === 1'b1) bsy_len <= (bsy_q === 1'b1) ? bsy_len + 1 : 1;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task summarize;
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task check(input string name, input logic [9:0] exp, input logic [9:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : check

  task check_rng(input string name, input int lo, input int hi, input int got);
    tests_run++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("unexpected %s: expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : check_rng

  task fail_out(input string name);
    error_cnt++;
    $display("unexpected %s: expected done seen timeout", name);
    summarize();
  endtask : fail_out

  task cmd_wr(input logic [1:0] a, input logic [9:0] v);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : cmd_wr

  task cmd_rd(input logic [1:0] a, output logic [9:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
    v = o_rdata;
  endtask : cmd_rd

  task link_wait;
    logic [9:0] st;
    for (int i = 0; i < 30; i++) begin
      cmd_rd(A_DEV_WRITE, st);
      if (st[ST_BUSY] === 1'b0) return;
    end
    fail_out("link idle");
  endtask : link_wait

  task dev_write(input logic [9:0] v);
    cmd_wr(A_DEV_WRITE, v);
    link_wait();
  endtask : dev_write

  task wait_conv;
    int i;
    for (i = 0; i < 40 && o_busy !== 1'b1; i++) @(posedge i_clk);
    if (o_busy !== 1'b1) fail_out("conversion start");
    for (i = 0; i < 400 && o_busy !== 1'b0; i++) @(posedge i_clk);
    if (o_busy !== 1'b0) fail_out("conversion end");
  endtask : wait_conv

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    logic [9:0] st;
    check("done flag", 10'h001, link_if.int_eoc);
    cmd_rd(A_DEV_WRITE, st);
    check("status", 10'h002, st & 10'h01B);
    check("clock source", SRC_OSC, o_clk_src);
  endtask : t_reset

  task t_sw_slow;
    int         i;
    logic [9:0] st;
    i_sample_code <= CODE_MAX;
    dev_write(10'h200);
    dev_write(10'h000);
    check("clock source", SRC_OSC, o_clk_src);
    cmd_rd(A_DEV_WRITE, st);
    check("config written", 10'h018, st & 10'h018);
    wait_conv();
    check("result", CODE_MAX, o_result);
    check("done flag", 10'h001, link_if.int_eoc);
    check_rng("busy length", 60, 70, bsy_len);
    for (i = 0; i < 40 && o_powered_down !== 1'b1; i++) @(posedge i_clk);
    check("power down", 10'h001, o_powered_down);
  endtask : t_sw_slow

  task t_ext;
    i_sample_code <= 10'h155;
    dev_write(10'h248);
    dev_write(10'h020);
    check("clock source", SRC_EXT, o_clk_src);
    wait_conv();
    check("result", 10'h155 ^ SIGN_FLIP, o_result);
    check_rng("busy length", 56, 72, bsy_len);
  endtask : t_ext

  task t_fast;
    i_sample_code <= 10'h000;
    dev_write(10'h000);
    check("clock source", SRC_OSC, o_clk_src);
    wait_conv();
    check("result", SIGN_FLIP, o_result);
    check_rng("busy length", 28, 36, bsy_len);
  endtask : t_fast

  task t_read;
    logic [9:0] v;
    cmd_wr(A_DEV_READ, 10'h000);
    link_wait();
    cmd_rd(A_DEV_READ, v);
    check("read data", SIGN_FLIP, v);
    cmd_rd(A_DEV_WRITE, v);
    check("result valid", 10'h000, v & 10'h004);
  endtask : t_read

  task t_hw;
    i_sample_code <= 10'h0F0;
    dev_write(10'h080);
    cmd_wr(A_HW_START, 10'h001);
    repeat (30) @(posedge i_clk);
    check("done flag", 10'h000, link_if.int_eoc);
    check("busy", 10'h001, o_busy);
    cmd_wr(A_HW_START, 10'h000);
    wait_conv();
    check("result", 10'h0F0 ^ SIGN_FLIP, o_result);
  endtask : t_hw

  // Main sequence
  initial begin
    i_clk         = 1'b0;
    i_resetn      = 1'b0;
    i_addr        = 2'h0;
    i_wdata       = 10'h000;
    i_wr          = 1'b0;
    i_rd          = 1'b0;
    i_sample_code = 10'h000;
    error_cnt     = 0;
    tests_run     = 0;
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    t_reset();
    t_sw_slow();
    t_ext();
    t_fast();
    t_read();
    t_hw();
    summarize();
  end
endmodule : adc_clock_and_host_config_bench
